//--- msbf_assertions.sv
// Port checker for the serial block formatter.
// Assumes binding to msbf_top with a single clock.
module msbf_assertions
  import msbf_pkg::*;
#(
  parameter int BIT_C = BIT_CYC
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_conv_done,
  input wire logic i_serial_en_n,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic o_serial_out_pin,
  input wire logic o_busy
);
  localparam int BLK_MIN = 169 * BIT_C;
  localparam int BLK_MAX = 170 * BIT_C + 64;
  logic prev_r, prev_nxt;
  logic [31:0] run_r, run_nxt, blk_r, blk_nxt;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // Run lengths of line and busy
  always_comb begin
    prev_nxt = o_serial_out_pin;
    run_nxt = (o_serial_out_pin != prev_r) ? 32'h1 : run_r + 32'h1;
    blk_nxt = o_busy ? blk_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge i_clk) begin
    prev_r <= i_nrst ? prev_nxt : 1'b1;
    run_r <= i_nrst ? run_nxt : 32'(BIT_C);
    blk_r <= i_nrst ? blk_nxt : 32'h0;
  end

  AST_IDLE_HIGH: assert property (!o_busy |-> o_serial_out_pin)
    else $error("line low while idle");
  AST_START: assert property (
    (!i_serial_en_n)[*6] ##0 (i_conv_done && !o_busy) |->
    ##[1:4] (o_busy && !o_serial_out_pin)) else $error("no start bit");
  AST_OFF_QUIET: assert property (
    i_serial_en_n[*6] ##0 (i_conv_done && !o_busy) |=> !o_busy[*4])
    else $error("block while disabled");
  AST_ZERO_RUN: assert property (
    o_serial_out_pin && !prev_r |->
    run_r % BIT_C == 0 && run_r <= 9 * BIT_C)
    else $error("low run not whole bits");
  AST_ONE_RUN: assert property (
    !o_serial_out_pin && prev_r |-> run_r >= BIT_C)
    else $error("high run too short");
  AST_BLOCK_LEN: assert property (
    !o_busy && blk_r != 0 |-> blk_r >= BLK_MIN && blk_r <= BLK_MAX)
    else $error("block length wrong");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");

  COV_BLOCK: cover property (!o_busy && blk_r != 0);
  COV_SLVERR: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule : msbf_assertions

bind msbf_top msbf_assertions #(.BIT_C(int'(BIT_CYC_M1_P) + 1)) chk_u (.*);

//--- msbf_host_rx.sv
// Host receiver model: decodes packets from the serial line.
// Assumes the line idles high and BIT_C clocks per bit.
module msbf_host_rx
  import msbf_pkg::*;
#(
  parameter int BIT_C = BIT_CYC
)
(
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_valid,
  output logic [6:0] o_data,
  output logic o_frame_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] sh;

  initial begin
    o_valid = 1'b0;
    o_data = 7'h00;
    o_frame_err = 1'b0;
    forever begin
      @(negedge i_line);
      repeat (BIT_C / 2) @(posedge i_clk);
      for (int i = 0; i < 10; i++) begin
        sh[i] = i_line;
        if (i < 9) repeat (BIT_C) @(posedge i_clk);
      end
      o_data <= sh[7:1];
      o_frame_err <= sh[0] | ~sh[9] | ~(^sh[8:1]);
      o_valid <= 1'b1;
      @(posedge i_clk);
      o_valid <= 1'b0;
    end
  end
endmodule : msbf_host_rx

//--- msbf_pkg.sv
// Package for the serial block formatter: codes, layouts, timing.
// Assumes a single 100 MHz system clock.
package msbf_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned BAUD = 19230;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam logic [12:0] BIT_CYC_M1 = 13'(BIT_CYC - 1);
  localparam logic [4:0] PKT_CNT = 5'h11;
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [2:0] FLAG_HDR = 3'h3;
  localparam logic [3:0] DIGIT_BASE_HI = 4'h3;
  localparam logic [6:0] CODE_CR = 7'h0d;
  localparam logic [6:0] CODE_LF = 7'h0a;
  localparam logic [6:0] CODE_DIGIT0 = 7'h30;
  localparam int unsigned OPT2_MAIN_OVR_BIT = 3;
  localparam int unsigned OPT2_SUB_OVR_BIT = 2;
  localparam logic [4:0] IDX_RANGE = 5'h00;
  localparam logic [4:0] IDX_MDIG3 = 5'h01;
  localparam logic [4:0] IDX_FUNC = 5'h05;
  localparam logic [4:0] IDX_STATUS = 5'h06;
  localparam logic [4:0] IDX_OPT1 = 5'h07;
  localparam logic [4:0] IDX_OPT2 = 5'h08;
  localparam logic [4:0] IDX_OPT3 = 5'h09;
  localparam logic [4:0] IDX_SDIG3 = 5'h0a;
  localparam logic [4:0] IDX_SRANGE = 5'h0e;
  localparam logic [4:0] IDX_CR = 5'h0f;
  localparam logic [4:0] IDX_LF = 5'h10;
  localparam logic [31:0] AXI_ADDR_CTRL = 32'h00000000;
  localparam logic [31:0] AXI_ADDR_MEAS = 32'h00000004;
  localparam logic [31:0] AXI_ADDR_FLAGS = 32'h00000008;
  localparam logic [31:0] AXI_ADDR_STAT = 32'h0000000c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic temp_unit_flag;
    logic temp_mode;
    logic low_battery_flag;
    logic inrush_triggered;
    logic duty_mode;
    logic duty_judge;
    logic dc_mode;
    logic ac_mode;
    logic auto_range;
    logic main_minus;
    logic main_overrange_flag;
    logic sub_overrange_flag;
    logic sub_hz_avail;
    logic maxmin_key;
    logic relative_key;
  } msbf_flags_t;

  typedef struct packed {
    logic [3:0] mdig3;
    logic [3:0] mdig2;
    logic [3:0] mdig1;
    logic [3:0] mdig0;
    logic [3:0] sdig3;
    logic [3:0] sdig2;
    logic [3:0] sdig1;
    logic [3:0] sdig0;
  } msbf_digits_t;

  typedef struct packed {
    logic [2:0] m_range;
    logic [2:0] s_range;
    logic [6:0] func_code;
  } msbf_mode_t;
endpackage : msbf_pkg

//--- msbf_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous level arriving from a pin.
module msbf_sync
  import msbf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_async,
  output logic o_level
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic lvl_r;
  logic lvl_nxt;

  always_comb begin
    sh_nxt = {sh_r[1:0], i_async};
    lvl_nxt = lvl_r;
    // Accept a change once stages two and three agree
    if (sh_r[1] == sh_r[2]) begin
      lvl_nxt = sh_r[2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sh_r <= 3'h7;
      lvl_r <= 1'h1;
    end else begin
      sh_r <= sh_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign o_level = lvl_r;
endmodule : msbf_sync

//--- msbf_top.sv
// Serial data block formatter for a dual-display meter.
// Assumes measurement data from the converter core; registers via AXI4-Lite.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
module msbf_top
  import msbf_pkg::*;
#(
  parameter logic [12:0] BIT_CYC_M1_P = BIT_CYC_M1
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_conv_done,
  input wire logic i_serial_en_n,
  input wire logic i_bar_select_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic o_serial_out_pin,
  output logic o_busy
);
  typedef enum logic [1:0] {
    MSBF_IDLE = 2'b00,
    MSBF_LOAD = 2'b01,
    MSBF_WAIT = 2'b11
  } msbf_state_t;

  msbf_state_t st_r;
  msbf_state_t st_nxt;
  logic [4:0] idx_r;
  logic [4:0] idx_nxt;
  logic [6:0] pkt_r;
  logic [6:0] pkt_nxt;
  logic [15:0] blocks_r;
  logic [15:0] blocks_nxt;
  logic tx_valid;
  logic tx_ready;
  logic en_lvl;
  logic bar_lvl;

  // Software-written snapshot of the converter's reading
  msbf_mode_t mode_r;
  msbf_mode_t mode_nxt;
  msbf_digits_t dig_r;
  msbf_digits_t dig_nxt;
  msbf_flags_t flg_r;
  msbf_flags_t flg_nxt;

  // AXI slave state
  logic aw_hold_r;
  logic aw_hold_nxt;
  logic [31:0] awaddr_r;
  logic [31:0] awaddr_nxt;
  logic w_hold_r;
  logic w_hold_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic [3:0] wstrb_r;
  logic [3:0] wstrb_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;

  logic [31:0] meas_word;
  logic [31:0] flags_word;
  logic [31:0] wmerge;
  logic do_write;

  msbf_sync u_en_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async(i_serial_en_n),
    .o_level(en_lvl)
  );

  msbf_sync u_bar_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async(i_bar_select_n),
    .o_level(bar_lvl)
  );

  msbf_uart_tx #(.BIT_CYC_M1_P(BIT_CYC_M1_P)) u_tx (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_valid(tx_valid),
    .i_data(pkt_r),
    .o_ready(tx_ready),
    .o_line(o_serial_out_pin)
  );

  function automatic logic [6:0] digit_code(input logic [3:0] d);
    digit_code = {DIGIT_BASE_HI[2:0], d};
  endfunction : digit_code

  // Packet content for a given slot
  function automatic logic [6:0] pkt_for(
    input logic [4:0] idx,
    input msbf_mode_t md,
    input msbf_digits_t dg,
    input msbf_flags_t fl,
    input logic bar_flag
  );
    logic judge;
    logic [6:0] opt2;
    judge = 1'h0;
    opt2 = {FLAG_HDR, 4'h0};
    judge = fl.inrush_triggered | (fl.duty_mode & fl.duty_judge);
    opt2[OPT2_MAIN_OVR_BIT] = fl.main_overrange_flag;
    opt2[OPT2_SUB_OVR_BIT] = fl.sub_overrange_flag;
    case (idx)
      IDX_RANGE: pkt_for = {4'h6, md.m_range};
      5'h01: pkt_for = digit_code(dg.mdig3);
      5'h02: pkt_for = digit_code(dg.mdig2);
      5'h03: pkt_for = digit_code(dg.mdig1);
      5'h04: pkt_for = digit_code(dg.mdig0);
      IDX_FUNC: pkt_for = md.func_code;
      IDX_STATUS: pkt_for = {FLAG_HDR,
        fl.temp_unit_flag & fl.temp_mode,
        fl.low_battery_flag, judge, bar_flag};
      IDX_OPT1: pkt_for = {FLAG_HDR, fl.dc_mode, fl.ac_mode,
        fl.auto_range, fl.main_minus};
      IDX_OPT2: pkt_for = opt2;
      IDX_OPT3: pkt_for = {FLAG_HDR, 3'h0, fl.sub_hz_avail
        & ~fl.maxmin_key & ~fl.relative_key};
      5'h0a: pkt_for = digit_code(dg.sdig3);
      5'h0b: pkt_for = digit_code(dg.sdig2);
      5'h0c: pkt_for = digit_code(dg.sdig1);
      5'h0d: pkt_for = digit_code(dg.sdig0);
      IDX_SRANGE: pkt_for = {4'h6, md.s_range};
      IDX_CR: pkt_for = CODE_CR;
      IDX_LF: pkt_for = CODE_LF;
      default: pkt_for = CODE_LF;
    endcase
  endfunction : pkt_for

  // Block sequencer
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    pkt_nxt = pkt_r;
    blocks_nxt = blocks_r;
    tx_valid = 1'h0;
    case (st_r)
      MSBF_IDLE: begin
        if (i_conv_done && !en_lvl && tx_ready) begin
          idx_nxt = 5'h0;
          st_nxt = MSBF_LOAD;
        end
      end
      MSBF_LOAD: begin
        pkt_nxt = pkt_for(idx_r, mode_r, dig_r, flg_r, ~bar_lvl);
        st_nxt = MSBF_WAIT;
      end
      MSBF_WAIT: begin
        tx_valid = 1'h1;
        if (tx_ready) begin
          if (idx_r == PKT_CNT - 5'h1) begin
            st_nxt = MSBF_IDLE;
            blocks_nxt = blocks_r + 16'h1;
          end else begin
            idx_nxt = idx_r + 5'h1;
            st_nxt = MSBF_LOAD;
          end
        end
      end
      default: st_nxt = MSBF_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_r <= MSBF_IDLE;
      idx_r <= 5'h0;
      pkt_r <= 7'h7f;
      blocks_r <= 16'h0;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      pkt_r <= pkt_nxt;
      blocks_r <= blocks_nxt;
    end
  end

  // Busy until the last stop bit is out
  assign o_busy = (st_r != MSBF_IDLE) || !tx_ready;

  // Register views
  assign meas_word = dig_r;
  assign flags_word = {17'h0, flg_r};

  always_comb begin
    wmerge = 32'h0;
    for (int b = 0; b < 4; b++) begin
      wmerge[b*8 +: 8] = wstrb_r[b] ? wdata_r[b*8 +: 8] : 8'h0;
    end
  end

  // AXI write and read channels
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    awaddr_nxt = awaddr_r;
    w_hold_nxt = w_hold_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    mode_nxt = mode_r;
    dig_nxt = dig_r;
    flg_nxt = flg_r;
    do_write = aw_hold_r && w_hold_r && !bvalid_r;
    if (s_axi_awvalid && !aw_hold_r) begin
      aw_hold_nxt = 1'h1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_r) begin
      w_hold_nxt = 1'h1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      aw_hold_nxt = 1'h0;
      w_hold_nxt = 1'h0;
      bvalid_nxt = 1'h1;
      bresp_nxt = RESP_OKAY;
      case (awaddr_r)
        AXI_ADDR_CTRL: mode_nxt = msbf_mode_t'(wmerge[12:0]);
        AXI_ADDR_MEAS: dig_nxt = msbf_digits_t'(wmerge);
        AXI_ADDR_FLAGS: flg_nxt = msbf_flags_t'(wmerge[14:0]);
        AXI_ADDR_STAT: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'h0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'h1;
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr)
        AXI_ADDR_CTRL: rdata_nxt = {19'h0, mode_r};
        AXI_ADDR_MEAS: rdata_nxt = meas_word;
        AXI_ADDR_FLAGS: rdata_nxt = flags_word;
        AXI_ADDR_STAT: rdata_nxt = {blocks_r, 9'h0, idx_r, ~bar_lvl,
          o_busy};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      aw_hold_r <= 1'h0;
      awaddr_r <= 32'h0;
      w_hold_r <= 1'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'h0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'h0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
      mode_r <= '0;
      dig_r <= '0;
      flg_r <= '0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      awaddr_r <= awaddr_nxt;
      w_hold_r <= w_hold_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      mode_r <= mode_nxt;
      dig_r <= dig_nxt;
      flg_r <= flg_nxt;
    end
  end

  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready = !w_hold_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule : msbf_top

//--- msbf_uart_tx.sv
// Serial character sender: start, 7 data LSB first, odd parity, stop.
// Assumes o_ready is sampled before i_valid is raised.
module msbf_uart_tx
  import msbf_pkg::*;
#(
  parameter logic [12:0] BIT_CYC_M1_P = BIT_CYC_M1
)
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_valid,
  input wire logic [6:0] i_data,
  output logic o_ready,
  output logic o_line
);
  logic [9:0] sh_r;
  logic [9:0] sh_nxt;
  logic [3:0] bits_r;
  logic [3:0] bits_nxt;
  logic [12:0] cyc_r;
  logic [12:0] cyc_nxt;
  logic line_r;
  logic line_nxt;

  always_comb begin
    sh_nxt = sh_r;
    bits_nxt = bits_r;
    cyc_nxt = cyc_r;
    line_nxt = line_r;
    if (bits_r == 4'h0) begin
      line_nxt = 1'h1;
      if (i_valid) begin
        sh_nxt = {1'h1, ~^i_data, i_data, 1'h0};
        bits_nxt = FRAME_BITS;
        cyc_nxt = BIT_CYC_M1_P;
        line_nxt = 1'h0;
      end
    end else if (cyc_r == 13'h0) begin
      cyc_nxt = BIT_CYC_M1_P;
      bits_nxt = bits_r - 4'h1;
      sh_nxt = {1'h1, sh_r[9:1]};
      line_nxt = (bits_r == 4'h1) ? 1'h1 : sh_r[1];
    end else begin
      cyc_nxt = cyc_r - 13'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sh_r <= 10'h3ff;
      bits_r <= 4'h0;
      cyc_r <= 13'h0;
      line_r <= 1'h1;
    end else begin
      sh_r <= sh_nxt;
      bits_r <= bits_nxt;
      cyc_r <= cyc_nxt;
      line_r <= line_nxt;
    end
  end

  assign o_ready = (bits_r == 4'h0);
  assign o_line = line_r;
endmodule : msbf_uart_tx

//--- testbench.sv
// Testbench for the serial block formatter: registers, then two blocks.
// Assumes msbf_host_rx decodes the line; short bit period, ~9k per block.
module testbench
  import msbf_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_nrst, i_conv_done, i_serial_en_n, i_bar_select_n;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, o_serial_out_pin, o_busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb;
  logic rx_valid, rx_err;
  logic [6:0] rx_data;
  logic [6:0] rx_q[$];
  logic [6:0] exp_q[$];
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  // Short bit period keeps the run brief
  localparam int TB_BIT = 50;

  msbf_top #(.BIT_CYC_M1_P(13'(TB_BIT - 1))) dut_u (.*);
  msbf_host_rx #(.BIT_C(TB_BIT)) host_u (.i_clk(i_clk),
    .i_line(o_serial_out_pin),
    .o_valid(rx_valid), .o_data(rx_data), .o_frame_err(rx_err));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (rx_valid) rx_q.push_back(rx_data);
    if (rx_valid) chk(32'(rx_err), 32'h0, "framing");
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic axw(input logic [31:0] a, d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge i_clk);
      if (s_axi_awvalid && s_axi_awready) aw = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w = 1'b1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    @(posedge i_clk);
    s_axi_bready <= 1'b1;
    do @(posedge i_clk); while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er), "bresp");
  endtask : axw

  task automatic axr(input logic [31:0] a, m, e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge i_clk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    @(posedge i_clk);
    s_axi_rready <= 1'b1;
    do @(posedge i_clk); while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e, "rdata");
    chk(32'(s_axi_rresp), 32'(er), "rresp");
  endtask : axr

  task automatic pulse();
    i_conv_done <= 1'b1;
    @(posedge i_clk);
    i_conv_done <= 1'b0;
  endtask : pulse

  task automatic wait_busy(input logic lvl);
    do @(posedge i_clk); while (o_busy !== lvl);
  endtask : wait_busy

  task automatic run_block();
    rx_q.delete();
    pulse();
    wait_busy(1'b1);
    repeat (100) @(posedge i_clk);
    pulse();
    wait_busy(1'b0);
    repeat (3 * TB_BIT) @(posedge i_clk);
    chk(32'(rx_q.size()), 32'd17, "packet count");
    foreach (exp_q[i]) chk(32'(rx_q[i]), 32'(exp_q[i]), "packet");
  endtask : run_block

  initial begin
    {i_nrst, i_conv_done, i_serial_en_n, i_bar_select_n} = 4'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    exp_q = '{{4'h6, 3'h5}, {3'h3, 4'h9}, {3'h3, 4'h0}, {3'h3, 4'h8},
      {3'h3, 4'h1}, 7'h34,
      {3'h3, 4'h7},
      {3'h3, 4'hb},
      {3'h3, 4'h8}, {3'h3, 4'h0},
      {3'h3, 4'h2}, {3'h3, 4'h7}, {3'h3, 4'h3}, {3'h3, 4'h4},
      {4'h6, 3'h2}, 7'h0d, 7'h0a};
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    axr(AXI_ADDR_CTRL, 32'hffffffff, 32'h0, RESP_OKAY);
    axr(AXI_ADDR_MEAS, 32'hffffffff, 32'h0, RESP_OKAY);
    axr(AXI_ADDR_FLAGS, 32'hffffffff, 32'h0, RESP_OKAY);
    axr(AXI_ADDR_STAT, 32'h3, 32'h0, RESP_OKAY);
    axr(32'h10, 32'hffffffff, 32'h0, RESP_SLVERR);
    axw(32'h10, 32'h1234, RESP_SLVERR);
    axw(AXI_ADDR_STAT, 32'hffffffff, RESP_OKAY);
    axw(AXI_ADDR_CTRL, 32'h1534, RESP_OKAY);
    axw(AXI_ADDR_MEAS, 32'h90812734, RESP_OKAY);
    axw(AXI_ADDR_FLAGS, 32'h5775, RESP_OKAY);
    axr(AXI_ADDR_CTRL, 32'hffffffff, 32'h1534, RESP_OKAY);
    axr(AXI_ADDR_MEAS, 32'hffffffff, 32'h90812734, RESP_OKAY);
    axr(AXI_ADDR_FLAGS, 32'hffffffff, 32'h5775, RESP_OKAY);
    $display("Test registers done");
    pulse();
    repeat (8) @(posedge i_clk);
    chk(32'(o_busy), 32'h0, "busy while disabled");
    i_serial_en_n <= 1'b0;
    i_bar_select_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    axr(AXI_ADDR_STAT, 32'h3, 32'h2, RESP_OKAY);
    $display("Test enable pins done");
    run_block();
    chk(32'(rx_q[6][1]), 32'h1, "duty judge");
    axr(AXI_ADDR_STAT, 32'hffff0003, 32'h00010002, RESP_OKAY);
    $display("Test serial block done");
    i_bar_select_n <= 1'b1;
    axw(AXI_ADDR_FLAGS, 32'h688c, RESP_OKAY);
    axr(AXI_ADDR_FLAGS, 32'hffffffff, 32'h688c, RESP_OKAY);
    // status: Celsius, inrush judge, bar off
    exp_q[6] = {3'h3, 4'ha};
    exp_q[7] = {3'h3, 4'h4};
    exp_q[8] = {3'h3, 4'h4};
    exp_q[9] = {3'h3, 4'h1};
    run_block();
    axr(AXI_ADDR_STAT, 32'hffff0003, 32'h00020000, RESP_OKAY);
    $display("Test flag block done");
    final_report();
  end
endmodule : testbench
